// ---- ppfpc_regs.vh ----
// Constants for the port pin function and pull-up control block.
// Assumes inclusion by the single design file ppfpc_top.v.
`ifndef PPFPC_REGS_VH
`define PPFPC_REGS_VH
`define PPFPC_PD_GPIO_W 6
`define PPFPC_PD_PUR_W 8
`define PPFPC_PE_PUR_W 2
`define PPFPC_PD_PUR_RST 8'hFF
`define PPFPC_PE_PUR_RST 2'h3
`define PPFPC_PD_SEL_RST 6'h00
`define PPFPC_SER_SEL_RST 4'hF
`define PPFPC_BIT_TX0 0
`define PPFPC_BIT_RX0 1
`define PPFPC_BIT_TX1 2
`define PPFPC_BIT_RX1 3
`define PPFPC_PD_TX1 6
`define PPFPC_PD_RX1 7
`define PPFPC_TCK_SYNC 2
`endif

// ---- ppfpc_top.v ----
// Pad function selection, pull-up control and test port pad sampling.
// Assumes synchronous inputs; test clock is sampled on the system clock.
//
// Behaviour
// - Each port D bit 0-5 is individually input or output.
// - After reset port D bits 0-5 are general-purpose I/O.
// - Memory-interface select turns port D 0-5 into chip selects 2-7.
// - Chip selects float while bus idles unless drive-select bit is set.
// - Clearing port D pull-up bit n turns off pin n pull-up.
// - Serial 0 transmit default after reset; port E bit 0 alternate.
// - Serial 0 receive default after reset; port E bit 1 alternate.
// - Serial 1 transmit default after reset; port D bit 6 alternate.
// - Serial 1 receive default after reset; port D bit 7 alternate.
// - Mode select sampled on rising test clock, steps TAP controller.
// - Test data input sampled serially on rising test clock.
// - Test data out driven only in shift states, changes on falling edge.
// - Test-port pull-up disable bit turns off mode and data-in pull-ups.
`timescale 1ns/10ps
`include "ppfpc_regs.vh"
module ppfpc_top (
    input wire I_CLOCK,
    input wire I_ARST_N,
    // Port D 0-5 general-purpose and chip select side
    input wire [5:0] I_PD_DIR,
    input wire [5:0] I_PD_OUT,
    input wire [5:0] I_PD_CS_SEL,
    input wire [5:0] I_CS_N,
    input wire I_EXT_BUS_ACTIVE,
    input wire I_BUS_IDLE_DRIVE_SELECT,
    input wire [5:0] I_PD_PAD_IN,
    output reg [5:0] O_PD_PAD_OUT,
    output reg [5:0] O_PD_PAD_OE,
    output reg [5:0] O_PD_IN,
    // Pull-up controls
    input wire [7:0] I_PORT_D_PULLUP_ENABLE,
    input wire [1:0] I_PORT_E_PULLUP_ENABLE,
    input wire I_PULLUP_DISABLE_TEST,
    input wire I_PULLUP_WR,
    output reg [7:0] O_PD_PULLUP,
    output reg [1:0] O_PE_PULLUP,
    output reg O_TEST_PULLUP,
    // Serial pads; select bit high means serial function
    input wire [3:0] I_SER_SEL,
    input wire [3:0] I_SER_GPIO_DIR,
    input wire [3:0] I_SER_GPIO_OUT,
    input wire I_SERIAL0_TRANSMIT,
    input wire I_SERIAL1_TRANSMIT,
    input wire [3:0] I_SER_PAD_IN,
    output reg [3:0] O_SER_PAD_OUT,
    output reg [3:0] O_SER_PAD_OE,
    output reg O_SERIAL0_RECEIVE,
    output reg O_SERIAL1_RECEIVE,
    output reg [3:0] O_SER_GPIO_IN,
    // Test port pads
    input wire I_TCK,
    input wire I_TMS,
    input wire I_TDI,
    input wire I_TAP_TDO,
    input wire I_TAP_SHIFT,
    output reg O_TAP_TMS,
    output reg O_TAP_TDI,
    output reg O_TAP_STEP,
    output reg O_TDO,
    output reg O_TDO_OE
);
    reg [1:0] rst_sync;
    wire rst_n;
    reg [`PPFPC_TCK_SYNC-1:0] tck_sync;
    reg tck_prev;
    wire tck_rise;
    wire tck_fall;
    reg [5:0] next_pd_out;
    reg [5:0] next_pd_oe;
    reg [3:0] next_ser_out;
    reg [3:0] next_ser_oe;
    reg [3:0] ser_sel;
    reg [5:0] pd_sel;
    // Loop indices, one for each combinational process
    integer i;
    integer j;

    assign rst_n = rst_sync[1];
    always @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end

    // Edge detection reads only the second synchroniser stage
    assign tck_rise = tck_sync[1] & ~tck_prev;
    assign tck_fall = ~tck_sync[1] & tck_prev;

    always @* begin
        for (i = 0; i < `PPFPC_PD_GPIO_W; i = i + 1) begin
            if (pd_sel[i]) begin
                next_pd_out[i] = I_CS_N[i];
                // Idle bus floats the select unless drive-select is set
                next_pd_oe[i] = I_EXT_BUS_ACTIVE |
                    I_BUS_IDLE_DRIVE_SELECT;
            end else begin
                next_pd_out[i] = I_PD_OUT[i];
                next_pd_oe[i] = I_PD_DIR[i];
            end
        end
    end

    // Serial pads; the loop index is compared with the transmit bit codes
    always @* begin
        // Transmit pads drive in serial mode; receive pads drive only in port mode
        next_ser_out = {I_SER_GPIO_OUT[3], I_SERIAL1_TRANSMIT,
            I_SER_GPIO_OUT[1], I_SERIAL0_TRANSMIT};
        next_ser_oe = I_SER_GPIO_DIR;
        for (j = 0; j < 4; j = j + 1) begin
            if (!ser_sel[j]) begin
                next_ser_out[j] = I_SER_GPIO_OUT[j];
            end else begin
                next_ser_oe[j] = (j == `PPFPC_BIT_TX0) ||
                    (j == `PPFPC_BIT_TX1);
            end
        end
    end

    // Select registers; pads follow one edge later, so a mode change
    // never reaches a pad through an unregistered path.
    always @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pd_sel <= `PPFPC_PD_SEL_RST;
            ser_sel <= `PPFPC_SER_SEL_RST;
        end else begin
            pd_sel <= I_PD_CS_SEL;
            ser_sel <= I_SER_SEL;
        end
    end

    // Port D pads 0-5 and their input path
    always @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_PD_PAD_OUT <= 6'h00;
            O_PD_PAD_OE <= 6'h00;
            O_PD_IN <= 6'h00;
        end else begin
            O_PD_PAD_OUT <= next_pd_out;
            O_PD_PAD_OE <= next_pd_oe;
            // Chip-select pins read as zero on the port side
            O_PD_IN <= I_PD_PAD_IN & ~pd_sel;
        end
    end

    // Pull-ups hold their setting between load strobes
    always @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_PD_PULLUP <= `PPFPC_PD_PUR_RST;
            O_PE_PULLUP <= `PPFPC_PE_PUR_RST;
            O_TEST_PULLUP <= 1'h1;
        end else if (I_PULLUP_WR) begin
            O_PD_PULLUP <= I_PORT_D_PULLUP_ENABLE;
            O_PE_PULLUP <= I_PORT_E_PULLUP_ENABLE;
            O_TEST_PULLUP <= ~I_PULLUP_DISABLE_TEST;
        end
    end

    // Serial pads and the receive paths into both serial ports
    always @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_SER_PAD_OUT <= 4'h0;
            O_SER_PAD_OE <= 4'h0;
            O_SERIAL0_RECEIVE <= 1'h1;
            O_SERIAL1_RECEIVE <= 1'h1;
            O_SER_GPIO_IN <= 4'h0;
        end else begin
            O_SER_PAD_OUT <= next_ser_out;
            O_SER_PAD_OE <= next_ser_oe;
            // Receivers idle high when their pad is lent to the port,
            // so a port-mode pad never looks like a start bit
            O_SERIAL0_RECEIVE <= ser_sel[`PPFPC_BIT_RX0] ?
                I_SER_PAD_IN[`PPFPC_BIT_RX0] : 1'h1;
            O_SERIAL1_RECEIVE <= ser_sel[`PPFPC_BIT_RX1] ?
                I_SER_PAD_IN[`PPFPC_BIT_RX1] : 1'h1;
            O_SER_GPIO_IN <= I_SER_PAD_IN & ~ser_sel;
        end
    end

    // Test clock oversampling; idle level low matches its pull-down
    always @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync <= 2'h0;
            tck_prev <= 1'h0;
        end else begin
            tck_sync <= {tck_sync[0], I_TCK};
            tck_prev <= tck_sync[1];
        end
    end

    // Mode select and data in, taken on the rising test clock
    always @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_TAP_TMS <= 1'h1;
            O_TAP_TDI <= 1'h1;
            O_TAP_STEP <= 1'h0;
        end else begin
            // Test clock must run well below a quarter of I_CLOCK
            O_TAP_STEP <= tck_rise;
            if (tck_rise) begin
                O_TAP_TMS <= I_TMS;
                O_TAP_TDI <= I_TDI;
            end
        end
    end

    // Data out and its enable move only on the falling test clock
    always @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_TDO <= 1'h0;
            O_TDO_OE <= 1'h0;
        end else if (tck_fall) begin
            O_TDO <= I_TAP_TDO;
            O_TDO_OE <= I_TAP_SHIFT;
        end
    end
endmodule // ppfpc_top

// ---- ppfpc_assertions.sv ----
// Checker for ppfpc_top: select drive, serial pads, test pins.
// Assumes test clock phases of six or more system clocks.
`timescale 1ns/10ps
module ppfpc_chk (
    input wire logic I_CLOCK, I_ARST_N, I_EXT_BUS_ACTIVE, I_TCK, I_TMS,
    input wire logic I_BUS_IDLE_DRIVE_SELECT, I_TDI, O_TDO, O_TDO_OE,
    input wire logic O_TAP_TMS, O_TAP_TDI, O_TAP_STEP,
    input wire logic [5:0] I_PD_CS_SEL, O_PD_PAD_OE,
    input wire logic [3:0] I_SER_SEL, O_SER_PAD_OE
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);
    wire idle = !I_EXT_BUS_ACTIVE && !I_BUS_IDLE_DRIVE_SELECT;
    chk_cs_float: assert property ((&I_PD_CS_SEL && idle)[*4] |->
        O_PD_PAD_OE == 6'h00) else $error("select driven on idle bus");
    chk_cs_drive: assert property ((&I_PD_CS_SEL && !idle)[*4] |->
        O_PD_PAD_OE == 6'h3F) else $error("select not driven");
    chk_tx_drive: assert property ((I_SER_SEL[2])[*5] |->
        O_SER_PAD_OE[2]) else $error("transmit pad not driven");
    chk_rx_float: assert property ((I_SER_SEL[3])[*5] |->
        !O_SER_PAD_OE[3]) else $error("receive pad driven");
    chk_step_rise: assert property ($rose(O_TAP_STEP) |-> I_TCK)
        else $error("step without test clock high");
    chk_step_once: assert property (O_TAP_STEP |=> !O_TAP_STEP [*5])
        else $error("extra step pulse");
    chk_tap_sample: assert property (O_TAP_STEP |-> O_TAP_TMS == I_TMS &&
        O_TAP_TDI == I_TDI) else $error("test pins missampled");
    chk_tdo_fall: assert property ($changed({O_TDO, O_TDO_OE}) |-> !I_TCK)
        else $error("data out moved with clock high");
    cover property (O_TAP_STEP && !O_TAP_TMS);
    cover property ($rose(O_TDO_OE));
    cover property (&I_PD_CS_SEL && !idle);
endmodule // ppfpc_chk
bind ppfpc_top ppfpc_chk u_chk (.*);

// ---- ppfpc_board.sv ----
// Board model: port D pad levels 0-5 from drive and pull-up.
// Assumes an undriven pad without pull-up floats; it toggles.
`timescale 1ns/10ps
module ppfpc_board (
    input wire logic [5:0] O_PD_PAD_OUT, O_PD_PAD_OE,
    input wire logic [7:0] O_PD_PULLUP,
    output logic [5:0] I_PD_PAD_IN
);
    logic [5:0] flt = 6'h00;
    always #10 flt = ~flt;
    assign I_PD_PAD_IN = O_PD_PAD_OE & O_PD_PAD_OUT |
        ~O_PD_PAD_OE & (O_PD_PULLUP[5:0] | flt);
endmodule // ppfpc_board

// ---- tb_top.sv ----
// Bench for ppfpc_top: pad muxing, pull-ups and test pins.
// Assumes ppfpc_board closes the port D pads.
`timescale 1ns/10ps
module tb_top;
    logic I_CLOCK = 0, I_ARST_N = 0, I_TCK = 0, I_PULLUP_WR = 0, I_TMS = 1;
    logic I_EXT_BUS_ACTIVE = 0, I_BUS_IDLE_DRIVE_SELECT = 0, I_TDI = 1;
    logic I_PULLUP_DISABLE_TEST = 0, I_SERIAL0_TRANSMIT = 0, O_TDO_OE;
    logic I_SERIAL1_TRANSMIT = 1, I_TAP_TDO = 1, I_TAP_SHIFT = 1, O_TDO;
    logic O_TEST_PULLUP, O_SERIAL0_RECEIVE, O_SERIAL1_RECEIVE, O_TAP_TMS;
    logic O_TAP_TDI, O_TAP_STEP;
    logic [5:0] I_PD_DIR = 6'h3F, I_PD_OUT = 6'h15, I_PD_CS_SEL = 6'h00;
    logic [5:0] I_CS_N = 6'h2A, I_PD_PAD_IN, O_PD_PAD_OUT, O_PD_PAD_OE, O_PD_IN;
    logic [7:0] I_PORT_D_PULLUP_ENABLE = 8'h5A, O_PD_PULLUP;
    logic [1:0] I_PORT_E_PULLUP_ENABLE = 2'h1, O_PE_PULLUP;
    logic [3:0] I_SER_SEL = 4'hF, I_SER_GPIO_DIR = 4'hF, I_SER_PAD_IN = 4'h5;
    logic [3:0] I_SER_GPIO_OUT = 4'hA, O_SER_PAD_OUT, O_SER_PAD_OE;
    logic [3:0] O_SER_GPIO_IN;
    int failures = 0, tests_run = 0, cyc = 0;
    ppfpc_top dut (.*);
    ppfpc_board board (.*);
    always #5 I_CLOCK = ~I_CLOCK;
    task chk(input logic [19:0] g, e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task st(input int n); repeat (n) @(negedge I_CLOCK); endtask
    task tck(input logic m, d); I_TMS = m; I_TDI = d; st(4);
        I_TCK = 1; st(8); I_TCK = 0; st(4); endtask
    task print_verdict;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge I_CLOCK) if (++cyc == 2000) begin
        failures++;
        print_verdict;
    end
    initial begin
        st(5); I_ARST_N = 1; st(6);
        chk({O_PD_PAD_OE, O_PD_PAD_OUT, O_PD_PULLUP}, 20'hFD5FF);
        chk({O_SER_PAD_OE, O_SER_PAD_OUT & 4'h5, O_SERIAL0_RECEIVE}, 9'hA8);
        chk(O_SERIAL1_RECEIVE, 1'h0);
        I_PULLUP_WR = 1; I_PULLUP_DISABLE_TEST = 1; I_SER_SEL = 4'h0;
        I_PD_DIR = 6'h2A; I_PD_OUT = 6'h00; st(1); I_PULLUP_WR = 0; st(5);
        chk({O_PD_PULLUP, O_PE_PULLUP, O_TEST_PULLUP}, 11'h2D2);
        chk({O_PD_PAD_OE, O_PD_IN & 6'h3A}, 12'hA90);
        chk({O_SER_PAD_OE, O_SER_PAD_OUT, O_SER_GPIO_IN}, 12'hFA5);
        chk({O_SERIAL0_RECEIVE, O_SERIAL1_RECEIVE}, 2'h3);
        I_PD_CS_SEL = 6'h3F; st(5);
        chk(O_PD_PAD_OE, 6'h00);
        I_EXT_BUS_ACTIVE = 1; st(5);
        chk({O_PD_PAD_OE, O_PD_PAD_OUT, O_PD_IN}, 18'h3FA80);
        I_EXT_BUS_ACTIVE = 0; I_BUS_IDLE_DRIVE_SELECT = 1; st(5);
        chk(O_PD_PAD_OE, 6'h3F);
        tck(0, 0);
        chk({O_TAP_TMS, O_TAP_TDI, O_TDO, O_TDO_OE}, 4'h3);
        I_TAP_SHIFT = 0; tck(1, 1);
        chk({O_TAP_TMS, O_TAP_TDI, O_TDO_OE}, 3'h6);
        print_verdict;
    end
endmodule // tb_top
